//--- hw/arm_alarm_ctrl.sv
// AHB-Lite alarm raw word, source mask, latched status and active-low alert.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module arm_alarm_ctrl (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Safety summaries.
   input wire logic [7:0] safety_status_a,
   input wire logic [7:0] safety_status_b,
   input wire logic [7:0] safety_alert_a,
   input wire logic [7:0] safety_alert_b,
   // Protection driver, shutdown and balancing levels.
   input wire logic charge_driver_off,
   input wire logic discharge_driver_off,
   input wire logic cell_below_shutdown,
   input wire logic stack_below_shutdown,
   input wire logic balance_active,
   // One-cycle event pulses.
   input wire logic full_scan_done,
   input wire logic adc_scan_done,
   input wire logic wake_event,
   input wire logic sleep_entered,
   input wire logic timer_expired_flag,
   input wire logic startup_done,
   // Detector, power-on and stored default mask.
   input wire logic charger_detect_level,
   input wire logic power_on_event,
   input wire logic [15:0] cfg_default_mask,
   // Alert pin.
   output logic alert_n
);

   arm_pkg::arm_state_t s_q;
   arm_pkg::arm_state_t s_d;
   logic [15:0] raw_w;
   logic [15:0] src_w;
   logic [15:0] rd_raw;
   logic [15:0] st_clr;
   logic sv_set;
   logic sv_clr;
   logic cd_change;
   logic ap_take;
   arm_pkg::arm_reg_t ap_reg;

   // Merges a hardware set with a software clear; the set wins so no event is lost.
   function automatic logic [15:0] sticky(input logic [15:0] old,
                                          input logic [15:0] set,
                                          input logic [15:0] clr);
      return set | (old & ~clr);
   endfunction

   // Maps a byte address onto a register; anything else reads zero and ignores writes.
   function automatic arm_pkg::arm_reg_t decode(input logic [31:0] addr);
      arm_pkg::arm_reg_t r;
      r = arm_pkg::REG_NONE;
      if (addr[31:8] == 24'h000000) begin
         case (addr[7:0])
            arm_pkg::RAW_OFS: r = arm_pkg::REG_RAW;
            arm_pkg::MASK_OFS: r = arm_pkg::REG_MASK;
            arm_pkg::STAT_OFS: r = arm_pkg::REG_STAT;
            default: r = arm_pkg::REG_NONE;
         endcase
      end
      return r;
   endfunction

   // The slave never stalls and never errors.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign alert_n = s_q.alert_n;

   assign ap_take = hsel && htrans[1] && hready;
   assign ap_reg = decode(haddr);

   // Change is held off in the load cycle so reset alone never fakes a toggle.
   assign cd_change = (s_q.phase == arm_pkg::ST_RUN) &&
                      (charger_detect_level != s_q.cd_prev);

   // Raw word shows the live sources, and the held shutdown flag at bit 9, with no regard to the mask.
   always_comb begin
      raw_w = 16'h0000;
      raw_w[arm_pkg::B_STAT_A] = |safety_status_a;
      raw_w[arm_pkg::B_STAT_B] = |safety_status_b;
      raw_w[arm_pkg::B_ALRT_A] = |safety_alert_a;
      raw_w[arm_pkg::B_ALRT_B] = |safety_alert_b;
      raw_w[arm_pkg::B_XCH] = charge_driver_off;
      raw_w[arm_pkg::B_XDS] = discharge_driver_off;
      raw_w[arm_pkg::B_SHUT] = s_q.shut_flag;
      raw_w[arm_pkg::B_BAL] = balance_active;
      raw_w[arm_pkg::B_FULL] = full_scan_done;
      raw_w[arm_pkg::B_ADC] = adc_scan_done;
      raw_w[arm_pkg::B_WAKE] = wake_event;
      raw_w[arm_pkg::B_SLP] = sleep_entered;
      raw_w[arm_pkg::B_TMR] = timer_expired_flag;
      raw_w[arm_pkg::B_INIT] = startup_done;
      raw_w[arm_pkg::B_CDET] = charger_detect_level;
      raw_w[arm_pkg::B_PWR] = power_on_event;
   end

   // Latch sources match the raw word except bit 1, which carries the change.
   always_comb begin
      src_w = raw_w;
      src_w[arm_pkg::B_CDET] = cd_change;
   end

   always_comb begin
      s_d = s_q;
      st_clr = 16'h0000;
      sv_clr = 1'b0;
      sv_set = cell_below_shutdown || stack_below_shutdown;
      rd_raw = raw_w;

      // Data phase of the previous transfer: writes land here.
      if (s_q.dp_wr) begin
         case (s_q.dp_reg)
            arm_pkg::REG_RAW: sv_clr = hwdata[arm_pkg::B_SHUT];
            arm_pkg::REG_MASK: s_d.mask = hwdata[15:0];
            arm_pkg::REG_STAT: st_clr = hwdata[15:0];
            default: st_clr = 16'h0000;
         endcase
      end

      s_d.shut_flag = sv_set || (s_q.shut_flag && !sv_clr);

      case (s_q.phase)
         arm_pkg::ST_LOAD: begin
            // The stored default is sampled after reset release, not under reset.
            s_d.mask = cfg_default_mask;
            s_d.cd_prev = charger_detect_level;
            s_d.phase = arm_pkg::ST_RUN;
         end
         arm_pkg::ST_RUN: begin
            s_d.cd_prev = charger_detect_level;
            // The mask in force this cycle gates latching, so a rewrite acts at once.
            s_d.status = sticky(s_q.status, src_w & s_d.mask, st_clr);
         end
         default: begin
            s_d.phase = arm_pkg::ST_LOAD;
         end
      endcase

      // Alert stays low while any latched bit or the shutdown flag stands.
      s_d.alert_n = !((|s_d.status) || s_d.shut_flag);

      // Address phase: capture the target and prepare read data.
      s_d.dp_wr = ap_take && hwrite;
      s_d.dp_reg = ap_take ? ap_reg : arm_pkg::REG_NONE;
      rd_raw[arm_pkg::B_SHUT] = s_d.shut_flag;
      if (ap_take && !hwrite) begin
         // Read data reflects any write completing in this same cycle.
         case (ap_reg)
            arm_pkg::REG_RAW: s_d.rdata = {16'h0000, rd_raw};
            arm_pkg::REG_MASK: s_d.rdata = {16'h0000, s_d.mask};
            arm_pkg::REG_STAT: s_d.rdata = {16'h0000, s_d.status};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.phase <= arm_pkg::ST_LOAD;
         s_q.mask <= arm_pkg::MASK_RST;
         s_q.status <= arm_pkg::STAT_RST;
         s_q.shut_flag <= 1'b0;
         s_q.cd_prev <= 1'b0;
         s_q.alert_n <= 1'b1;
         s_q.dp_wr <= 1'b0;
         s_q.dp_reg <= arm_pkg::REG_NONE;
         s_q.rdata <= 32'h00000000;
      end else begin
         s_q <= s_d;
      end
   end

   // Upper half of every read is zero.
   property p_raw_upper;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite) |=> (hrdata[31:16] == 16'h0000);
   endproperty
   a_raw_upper: assert property (p_raw_upper)
      else $error("Upper read data bits not zero.");

   property p_raw_stat_a;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_STAT_A] == ($past(safety_status_a) != 8'h00));
   endproperty
   a_raw_stat_a: assert property (p_raw_stat_a)
      else $error("Raw bit 15 does not follow safety status A.");

   property p_raw_xch;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[11] == $past(charge_driver_off));
   endproperty
   a_raw_xch: assert property (p_raw_xch)
      else $error("Raw bit 11 does not follow the charge driver.");

   property p_raw_stat_b;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_STAT_B] == ($past(safety_status_b) != 8'h00));
   endproperty
   a_raw_stat_b: assert property (p_raw_stat_b)
      else $error("Raw bit 14 does not follow safety status B.");

   property p_raw_alrt_a;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_ALRT_A] == ($past(safety_alert_a) != 8'h00));
   endproperty
   a_raw_alrt_a: assert property (p_raw_alrt_a)
      else $error("Raw bit 13 does not follow safety alert A.");

   property p_raw_alrt_b;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_ALRT_B] == ($past(safety_alert_b) != 8'h00));
   endproperty
   a_raw_alrt_b: assert property (p_raw_alrt_b)
      else $error("Raw bit 12 does not follow safety alert B.");

   property p_raw_xds;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_XDS] == $past(discharge_driver_off));
   endproperty
   a_raw_xds: assert property (p_raw_xds)
      else $error("Raw bit 10 does not follow the discharge driver.");

   property p_raw_bal;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_BAL] == $past(balance_active));
   endproperty
   a_raw_bal: assert property (p_raw_bal)
      else $error("Raw bit 8 does not follow cell balancing.");

   property p_raw_full;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_FULL] == $past(full_scan_done));
   endproperty
   a_raw_full: assert property (p_raw_full)
      else $error("Raw bit 7 does not follow the full scan pulse.");

   property p_raw_adc;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_ADC] == $past(adc_scan_done));
   endproperty
   a_raw_adc: assert property (p_raw_adc)
      else $error("Raw bit 6 does not follow the voltage scan pulse.");

   property p_raw_cdet;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_CDET] == $past(charger_detect_level));
   endproperty
   a_raw_cdet: assert property (p_raw_cdet)
      else $error("Raw bit 1 does not follow the detector level.");

   property p_raw_pwr;
      @(posedge hclk) disable iff (!hresetn)
      (ap_take && !hwrite && ap_reg == arm_pkg::REG_RAW)
         |=> (hrdata[arm_pkg::B_PWR] == $past(power_on_event));
   endproperty
   a_raw_pwr: assert property (p_raw_pwr)
      else $error("Raw bit 0 does not follow the power-on indication.");

   property p_shut_alert;
      @(posedge hclk) disable iff (!hresetn)
      (cell_below_shutdown || stack_below_shutdown) |=> (s_q.shut_flag && !alert_n);
   endproperty
   a_shut_alert: assert property (p_shut_alert)
      else $error("Shutdown condition did not set flag and alert.");

   property p_shut_clear;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.dp_wr && s_q.dp_reg == arm_pkg::REG_RAW && hwdata[arm_pkg::B_SHUT] &&
       !cell_below_shutdown && !stack_below_shutdown) |=> !s_q.shut_flag;
   endproperty
   a_shut_clear: assert property (p_shut_clear)
      else $error("Shutdown flag not cleared by write of one.");

   property p_mask_write;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.dp_wr && s_q.dp_reg == arm_pkg::REG_MASK) |=> (s_q.mask == $past(hwdata[15:0]));
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("Mask write not applied.");

   property p_mask_load;
      @(posedge hclk) disable iff (!hresetn)
      // The sampled reset keeps out the release edge, where the mask still holds its reset value.
      (hresetn && s_q.phase == arm_pkg::ST_LOAD) |=>
         (s_q.mask == $past(cfg_default_mask) && s_q.phase == arm_pkg::ST_RUN);
   endproperty
   a_mask_load: assert property (p_mask_load)
      else $error("Mask not loaded from stored default after reset.");

   property p_load_quiet;
      @(posedge hclk) disable iff (!hresetn)
      (hresetn && s_q.phase == arm_pkg::ST_LOAD) |=> (s_q.status == arm_pkg::STAT_RST);
   endproperty
   a_load_quiet: assert property (p_load_quiet)
      else $error("Status latched during the load cycle.");

   property p_pulse_latch;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.phase == arm_pkg::ST_RUN && full_scan_done && s_q.mask[7] &&
       !(s_q.dp_wr && s_q.dp_reg == arm_pkg::REG_MASK)) |=> s_q.status[7];
   endproperty
   a_pulse_latch: assert property (p_pulse_latch)
      else $error("Enabled scan pulse not latched.");

   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.status[3] && !(s_q.dp_wr && s_q.dp_reg == arm_pkg::REG_STAT)) |=> s_q.status[3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("Latched timer bit lost without a clear.");

   property p_alert_level;
      @(posedge hclk) disable iff (!hresetn)
      ((|s_q.status) || s_q.shut_flag) |-> !alert_n;
   endproperty
   a_alert_level: assert property (p_alert_level)
      else $error("Alert high while a latched bit is set.");

   property p_alert_release;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.status == 16'h0000 && !s_q.shut_flag) |-> alert_n;
   endproperty
   a_alert_release: assert property (p_alert_release)
      else $error("Alert low with nothing latched.");

   property p_cd_toggle;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.phase == arm_pkg::ST_RUN && $past(s_q.phase) == arm_pkg::ST_RUN &&
       $changed(charger_detect_level) && s_q.mask[1] &&
       !(s_q.dp_wr && s_q.dp_reg == arm_pkg::REG_MASK)) |=> s_q.status[1];
   endproperty
   a_cd_toggle: assert property (p_cd_toggle)
      else $error("Detector change not latched.");

endmodule

//--- shared/arm_pkg.sv
// Constants and types for the alarm raw status, mask and latched status block.
// Overview of operation
// - Raw alarm word, bits 15..0, shows every source except bit 9 unlatched and ignores the mask.
// - Raw bit 15 is set while any bit of safety status word A is set.
// - Raw bit 14 is set while any bit of safety status word B is set.
// - Raw bit 13 is set while any bit of safety alert word A is set.
// - Raw bit 12 is set while any bit of safety alert word B is set.
// - Raw bit 11 is set while the charge protection driver is disabled.
// - Raw bit 10 is set while the discharge protection driver is disabled.
// - Raw bit 9 sets when a cell or the stack is below shutdown threshold.
// - Writing 1 to raw bit 9 clears it; while set the alert pin is low.
// - Raw bit 8 is set while cell balancing runs.
// - Raw bit 7 pulses when a full scan completes.
// - Raw bit 6 pulses when a voltage ADC scan completes.
// - Raw bit 5 pulses on wake from sleep; bit 4 pulses on sleep entry.
// - Raw bit 3 pulses each time the programmable timer expires.
// - Raw bit 2 pulses when the startup measurement sequence finishes.
// - Raw bit 1 follows the charge detector output level.
// - Raw bit 0 is set while the battery power-on indication is asserted.
// - Sixteen-bit mask has the raw layout, but bit 1 selects detector change.
// - Software may rewrite the mask any time and it takes effect at once.
// - After reset the mask loads from the stored default mask setting.
// - Latched bit sets when its source and mask bit are set, and stays set.
// - Writing 1 clears a latched bit; any set latched bit drives alert low.
// - Detector change is raised when the debounced detector differs from before.
package arm_pkg;
   localparam logic [7:0] RAW_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   localparam int B_STAT_A = 15;
   localparam int B_STAT_B = 14;
   localparam int B_ALRT_A = 13;
   localparam int B_ALRT_B = 12;
   localparam int B_XCH = 11;
   localparam int B_XDS = 10;
   localparam int B_SHUT = 9;
   localparam int B_BAL = 8;
   localparam int B_FULL = 7;
   localparam int B_ADC = 6;
   localparam int B_WAKE = 5;
   localparam int B_SLP = 4;
   localparam int B_TMR = 3;
   localparam int B_INIT = 2;
   localparam int B_CDET = 1;
   localparam int B_PWR = 0;

   typedef enum logic {ST_LOAD, ST_RUN} arm_phase_t;

   typedef enum logic [1:0] {REG_RAW, REG_MASK, REG_STAT, REG_NONE} arm_reg_t;

   typedef struct packed {
      arm_phase_t phase;
      logic [15:0] mask;
      logic [15:0] status;
      logic shut_flag;
      logic cd_prev;
      logic alert_n;
      logic dp_wr;
      arm_reg_t dp_reg;
      logic [31:0] rdata;
   } arm_state_t;
endpackage

//--- tb/alarm_raw_status_and_mask_tb.sv
// Self-checking bench for the alarm raw word, mask, latched status and alert pin.
`timescale 1ns/1ps

module alarm_raw_status_and_mask_tb;
   localparam logic [31:0] A_RAW = {24'h0, arm_pkg::RAW_OFS};
   localparam logic [31:0] A_MSK = {24'h0, arm_pkg::MASK_OFS};
   localparam logic [31:0] A_STA = {24'h0, arm_pkg::STAT_OFS};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, alert_n, cell_low, stack_low;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] lv, dflt;
   logic [7:2] pv;
   int error_cnt, n_tests;

   arm_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   arm_alarm_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .safety_status_a(lv[15] ? 8'h40 : 8'h00), .safety_status_b(lv[14] ? 8'h01 : 8'h00),
      .safety_alert_a(lv[13] ? 8'h80 : 8'h00), .safety_alert_b(lv[12] ? 8'h10 : 8'h00),
      .charge_driver_off(lv[11]), .discharge_driver_off(lv[10]),
      .cell_below_shutdown(cell_low), .stack_below_shutdown(stack_low),
      .balance_active(lv[8]), .full_scan_done(pv[7]), .adc_scan_done(pv[6]),
      .wake_event(pv[5]), .sleep_entered(pv[4]), .timer_expired_flag(pv[3]),
      .startup_done(pv[2]), .charger_detect_level(lv[1]), .power_on_event(lv[0]),
      .cfg_default_mask(dflt), .alert_n(alert_n));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_reg(input logic [31:0] a);
      host.xfer(a, 1'b0, 32'h0000_0000, rd);
   endtask

   // Ends two edges after the write so that the alert pin has settled.
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      host.xfer(a, 1'b1, d, dummy);
      repeat (2) @(posedge hclk);
   endtask

   task automatic t_reset;
      rd_reg(A_MSK);
      chk(rd, {16'h0000, dflt});
      rd_reg(A_STA);
      chk(rd, 32'h0000_0000);
      wr_reg(32'h0000_000c, 32'hffff_ffff);
      rd_reg(32'h0000_000c);
      chk(rd, 32'h0000_0000);
      rd_reg(A_MSK);
      chk(rd, {16'h0000, dflt});
      chk({29'h0, hreadyout, hresp, alert_n}, 32'h0000_0005);
   endtask

   task automatic t_levels;
      wr_reg(A_MSK, 32'h0000_0000);
      for (int b = 0; b < 16; b++) begin
         if (b inside {[2:7], 9}) continue;
         lv <= 16'h0001 << b;
         @(posedge hclk);
         rd_reg(A_RAW);
         chk(rd, 32'h1 << b);
         lv <= 16'h0000;
         @(posedge hclk);
      end
      rd_reg(A_STA);
      chk(rd, 32'h0000_0000);
   endtask

   // Shutdown must stick and pull the alert low even with the mask fully closed.
   task automatic t_shutdown;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) cell_low <= 1'b1;
         else stack_low <= 1'b1;
         @(posedge hclk);
         cell_low <= 1'b0;
         stack_low <= 1'b0;
         repeat (2) @(posedge hclk);
         rd_reg(A_RAW);
         chk(rd, 32'h0000_0200);
         chk({31'h0, alert_n}, 32'h0000_0000);
         wr_reg(A_RAW, 32'h0000_0200);
         rd_reg(A_RAW);
         chk(rd, 32'h0000_0000);
         chk({31'h0, alert_n}, 32'h0000_0001);
      end
   endtask

   task automatic t_pulses;
      wr_reg(A_MSK, 32'h0000_ffff);
      for (int b = 2; b < 8; b++) begin
         pv[b] <= 1'b1;
         fork
            rd_reg(A_RAW);
            begin
               @(posedge hclk);
               pv[b] <= 1'b0;
            end
         join
         chk(rd, 32'h1 << b);
         rd_reg(A_STA);
         chk(rd, 32'h1 << b);
         chk({31'h0, alert_n}, 32'h0000_0000);
         wr_reg(A_STA, 32'h1 << b);
         rd_reg(A_STA);
         chk(rd, 32'h0000_0000);
         chk({31'h0, alert_n}, 32'h0000_0001);
      end
   endtask

   task automatic t_mask;
      wr_reg(A_MSK, 32'h0000_0000);
      lv[8] <= 1'b1;
      repeat (2) @(posedge hclk);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0000);
      wr_reg(A_MSK, 32'h0000_0100);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0100);
      lv[8] <= 1'b0;
      repeat (2) @(posedge hclk);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0100);
      wr_reg(A_STA, 32'h0000_0100);
      chk({31'h0, alert_n}, 32'h0000_0001);
   endtask

   // A steady detector level must not latch; only its edges do.
   task automatic t_toggle;
      wr_reg(A_MSK, 32'h0000_0002);
      lv[1] <= 1'b1;
      repeat (2) @(posedge hclk);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0002);
      wr_reg(A_STA, 32'h0000_0002);
      repeat (3) @(posedge hclk);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0000);
      lv[1] <= 1'b0;
      repeat (2) @(posedge hclk);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0002);
      wr_reg(A_STA, 32'h0000_0002);
   endtask

   // A mid-run reset must reload the default and keep a steady detector level from latching.
   task automatic t_rst2;
      lv[1] <= 1'b1;
      repeat (2) @(posedge hclk);
      chk({31'h0, alert_n}, 32'h0000_0000);
      hresetn <= 1'b0;
      @(posedge hclk);
      chk(hrdata, 32'h0000_0000);
      chk({31'h0, alert_n}, 32'h0000_0001);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd_reg(A_MSK);
      chk(rd, {16'h0000, dflt});
      rd_reg(A_STA);
      chk(rd, 32'h0000_0000);
      lv[1] <= 1'b0;
      repeat (2) @(posedge hclk);
      rd_reg(A_STA);
      chk(rd, 32'h0000_0002);
   endtask

   task automatic report_and_stop;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end

   initial begin
      hresetn = 1'b0;
      lv = 16'h0000;
      pv = 6'h00;
      cell_low = 1'b0;
      stack_low = 1'b0;
      dflt = 16'h8423;
      error_cnt = 0;
      n_tests = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_levels();
      t_shutdown();
      t_pulses();
      t_mask();
      t_toggle();
      t_rst2();
      report_and_stop();
   end
endmodule

//--- tb/arm_host_model.sv
// Host side bus master that reads and writes the alarm registers.
`timescale 1ns/1ps

module arm_host_model (
   // Bus clock and slave answer.
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Bus request.
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // Called just after a rising edge; each phase is held until hready is seen high.
   // A read leaves hwdata inverted so that a stale value is never mistaken for data.
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : ~hwdata;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
endmodule
